//--- bbsp_assertions.sv
// Pin-level checker for the static memory host port
`timescale 1ns/1ns
module bbsp_checker (
  input wire logic CLK_I, // Clock
  input wire logic NRST_I, // Reset
  input wire logic REQ_READY_O, // Ready
  input wire logic RSP_VALID_O, // Done
  input wire logic RSP_ERR_O, // Abort
  input wire bbsp_pkg::bbsp_supply_t SUPPLY_I, // Supply
  input wire bbsp_pkg::bbsp_pins_t MEM_PINS_O, // Pins
  input wire logic [bbsp_pkg::DATA_W-1:0] DATA_BUS_O, // Bus out
  input wire logic DATA_BUS_OE_O // Bus enable
);
  wire sel_n = MEM_PINS_O.sel_n;
  wire oe_n = MEM_PINS_O.oe_n;
  wire we_n = MEM_PINS_O.we_n;
  wire up = SUPPLY_I == bbsp_pkg::SUPPLY_NORMAL;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // ==========
  // Pin timing and power-fail handling
  strobe_width_a: assert property ($fell(we_n) |-> (!we_n || !up) [*8])
    else $error("short strobe");
  oe_off_write_a: assert property (!we_n |-> oe_n) else $error("oe in write");
  addr_steady_a: assert property (!sel_n && $past(!sel_n) |-> $stable(MEM_PINS_O.addr))
    else $error("addr moved");
  data_hold_a: assert property ($rose(we_n) && $past(up) |-> DATA_BUS_OE_O &&
    $stable(DATA_BUS_O) ##1 $stable(MEM_PINS_O.addr)) else $error("hold lost");
  no_clash_a: assert property (!oe_n |-> !DATA_BUS_OE_O) else $error("contention");
  read_time_a: assert property ($fell(oe_n) |-> (!RSP_VALID_O || RSP_ERR_O) [*8] ##3
    (RSP_VALID_O || RSP_ERR_O)) else $error("read timing");
  cycle_time_a: assert property ($fell(sel_n) |=> !$fell(sel_n) [*8] ##1 !$fell(sel_n))
    else $error("cycle short");
  supply_off_a: assert property (!up |=> sel_n && we_n && oe_n && !DATA_BUS_OE_O)
    else $error("access in fail");
  recovery_wait_a: assert property (up && $past(!up) |-> !REQ_READY_O [*8])
    else $error("no recovery");
  cover property ($fell(we_n));
  cover property ($fell(oe_n));
  cover property (RSP_ERR_O);
endmodule // bbsp_checker

bind bbsp_host bbsp_checker i_chk (.CLK_I(CLK_I), .NRST_I(NRST_I), .REQ_READY_O(REQ_READY_O),
  .RSP_VALID_O(RSP_VALID_O), .RSP_ERR_O(RSP_ERR_O), .SUPPLY_I(SUPPLY_I),
  .MEM_PINS_O(MEM_PINS_O), .DATA_BUS_O(DATA_BUS_O), .DATA_BUS_OE_O(DATA_BUS_OE_O));

//--- bbsp_host.sv
// Host controller driving the battery-backed static memory through its pins
`timescale 1ns/1ns
module bbsp_host (
  input wire logic CLK_I, // 100 MHz clock
  input wire logic NRST_I, // Synchronous reset, active low
  input wire logic REQ_VALID_I, // Access request
  output logic REQ_READY_O, // Request accepted
  input wire bbsp_pkg::bbsp_req_t REQ_I, // Request type, address, write data
  output logic RSP_VALID_O, // Access done, one-cycle pulse
  output logic [bbsp_pkg::DATA_W-1:0] RSP_RDATA_O, // Read data
  output logic RSP_ERR_O, // Access aborted by power failure
  input wire bbsp_pkg::bbsp_supply_t SUPPLY_I, // Supply state
  output bbsp_pkg::bbsp_pins_t MEM_PINS_O, // Select, enables, address
  input wire logic [bbsp_pkg::DATA_W-1:0] DATA_BUS_I, // Data bus level in
  output logic [bbsp_pkg::DATA_W-1:0] DATA_BUS_O, // Data bus drive value
  output logic DATA_BUS_OE_O // Data bus output enable
);
  typedef enum logic [2:0] {
    ST_RECOVER,
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_WHOLD,
    ST_GAP
  } bbsp_state_t;

  bbsp_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  bbsp_pkg::bbsp_pins_t pins_q, pins_d;
  logic [bbsp_pkg::DATA_W-1:0] wdata_q, wdata_d;
  logic [bbsp_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic oe_q, oe_d;
  logic rsp_q, rsp_d;
  logic err_q, err_d;

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire logic supply_ok = (SUPPLY_I == bbsp_pkg::SUPPLY_NORMAL);
  wire logic cnt_done = (cnt_q == bbsp_pkg::CNT_ZERO);
  wire logic [7:0] cnt_dec = cnt_q - 8'h01;
  wire logic take = REQ_VALID_I && (state_q == ST_IDLE) && supply_ok;
  // Access in flight that a supply fault would cut
  wire logic in_access = state_q inside {ST_READ, ST_WRITE, ST_WHOLD};
  wire bbsp_pkg::bbsp_pins_t pins_idle = '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: pins_q.addr};

  assign REQ_READY_O = (state_q == ST_IDLE) && supply_ok;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_dec;
    pins_d = pins_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    oe_d = oe_q;
    rsp_d = 1'b0;
    err_d = err_q;
    if (!supply_ok) begin
      // Deselect and float at once; abort any access in flight
      pins_d = pins_idle;
      oe_d = 1'b0;
      if (in_access) begin
        rsp_d = 1'b1;
        err_d = 1'b1;
      end
      state_d = ST_RECOVER;
      cnt_d = 8'(bbsp_pkg::RECOVERY_CYC);
    end else begin
      unique case (state_q)
        ST_RECOVER: begin
          if (cnt_done) begin
            state_d = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (take) begin
            err_d = 1'b0;
            pins_d.addr = REQ_I.addr;
            pins_d.sel_n = 1'b0;
            wdata_d = REQ_I.wdata;
            if (REQ_I.wr) begin
              // Select low first, strobe next cycle
              pins_d.oe_n = 1'b1;
              state_d = ST_WRITE;
              cnt_d = 8'(bbsp_pkg::STROBE_CYC);
            end else begin
              pins_d.oe_n = 1'b0;
              pins_d.we_n = 1'b1;
              state_d = ST_READ;
              cnt_d = 8'(bbsp_pkg::READ_CYC - 1);
            end
          end
        end
        ST_READ: begin
          if (cnt_done) begin
            // Sample only after all access times elapsed
            rdata_d = DATA_BUS_I;
            rsp_d = 1'b1;
            pins_d = pins_idle;
            state_d = ST_GAP;
            cnt_d = 8'(bbsp_pkg::FLOAT_CYC - 1);
          end
        end
        ST_WRITE: begin
          if (pins_q.we_n) begin
            pins_d.we_n = 1'b0;
            oe_d = 1'b1;
          end else if (cnt_done) begin
            pins_d.we_n = 1'b1;
            state_d = ST_WHOLD;
            cnt_d = 8'(bbsp_pkg::HOLD_CYC - 1);
          end
        end
        ST_WHOLD: begin
          if (cnt_done) begin
            // Data and address held past strobe rise
            pins_d.sel_n = 1'b1;
            oe_d = 1'b0;
            rsp_d = 1'b1;
            state_d = ST_GAP;
            cnt_d = 8'(bbsp_pkg::HOLD_CYC - 1);
          end
        end
        ST_GAP: begin
          if (cnt_done) begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Sequencer state and cycle counter
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      state_q <= ST_RECOVER;
      cnt_q <= 8'(bbsp_pkg::RECOVERY_CYC);
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Pins parked deselected after reset
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      pins_q <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
    end else begin
      pins_q <= pins_d;
    end
  end

  // Write data and bus drive enable
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      wdata_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      wdata_q <= wdata_d;
      oe_q <= oe_d;
    end
  end

  // Response pulse, read data and abort flag
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      rdata_q <= 8'h00;
      rsp_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rsp_q <= rsp_d;
      err_q <= err_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Data outputs straight from flip-flops
  assign MEM_PINS_O = pins_q;
  assign DATA_BUS_O = wdata_q;
  assign DATA_BUS_OE_O = oe_q;
  assign RSP_VALID_O = rsp_q;
  assign RSP_RDATA_O = rdata_q;
  assign RSP_ERR_O = err_q;
endmodule // bbsp_host

//--- bbsp_mem_model.sv
// Behavioural model of the battery-backed static memory
`timescale 1ns/1ns
module bbsp_mem_model (
  input wire bbsp_pkg::bbsp_pins_t pins_i, // Pins
  input wire bbsp_pkg::bbsp_supply_t supply_i, // Supply
  input wire logic [7:0] host_d_i, // Host data
  input wire logic host_oe_i, // Host drives
  output logic [7:0] bus_o // Bus level
);
  logic [7:0] mem [8192];
  time t_chg = 0;
  wire up = supply_i == bbsp_pkg::SUPPLY_NORMAL;
  wire rd = up && !pins_i.sel_n && !pins_i.oe_n && pins_i.we_n;
  wire wr = up && !pins_i.sel_n && !pins_i.we_n;
  initial bus_o = 8'h00;
  always @(pins_i.addr, rd) t_chg = $time;
  always @(negedge wr) if (up) mem[pins_i.addr] = bus_o;
  // Released or not yet valid: inverted each tick
  always #1 begin
    if (host_oe_i) bus_o = host_d_i;
    else if (rd && $time - t_chg >= 99) bus_o = mem[pins_i.addr];
    else bus_o = ~bus_o;
  end
endmodule // bbsp_mem_model

//--- bbsp_pkg.sv
// Package: timing constants and carrier types for the static memory host port
package bbsp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  // Read timing
  localparam int ADDRESS_ACCESS_TIME_NS = 100;
  localparam int SELECT_ACCESS_TIME_NS = 100;
  localparam int OUTPUT_ACCESS_TIME_NS = 50;
  localparam int SELECT_FLOAT_TIME_NS = 50;
  localparam int OUTPUT_FLOAT_TIME_NS = 40;
  localparam int CYCLE_TIME_NS = 100;
  // Write timing
  localparam int STROBE_WIDTH_NS = 80;
  localparam int ADDR_TO_END_NS = 80;
  localparam int DATA_SETUP_STROBE_NS = 50;
  localparam int DATA_HOLD_STROBE_NS = 5;
  localparam int STROBE_ADDRESS_HOLD_NS = 10;
  localparam int WRITE_FLOAT_TIME_NS = 50;
  localparam int RECOVERY_TIME_NS = 200;
  // Derived cycle counts, least times rounded up
  localparam int READ_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (SELECT_FLOAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (STROBE_ADDRESS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = (RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CNT_ZERO = 8'h00;

  typedef enum logic [1:0] {
    SUPPLY_NORMAL,
    SUPPLY_DESELECT,
    SUPPLY_BATTERY
  } bbsp_supply_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bbsp_req_t;

  typedef struct packed {
    logic sel_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
  } bbsp_pins_t;
endpackage

//--- tb.sv
// Self-checking bench for the static memory host port
`timescale 1ns/1ns
module tb;
  logic clk, nrst, vld, rdy, rspv, err, bus_oe;
  logic [7:0] rdat, bus_i, bus_o;
  bbsp_pkg::bbsp_req_t req;
  bbsp_pkg::bbsp_supply_t sup;
  bbsp_pkg::bbsp_pins_t pins;
  int num_errors = 0;
  int n_tests = 0;
  bbsp_host i_dut (.CLK_I(clk), .NRST_I(nrst), .REQ_VALID_I(vld), .REQ_READY_O(rdy),
    .REQ_I(req), .RSP_VALID_O(rspv), .RSP_RDATA_O(rdat), .RSP_ERR_O(err), .SUPPLY_I(sup),
    .MEM_PINS_O(pins), .DATA_BUS_I(bus_i), .DATA_BUS_O(bus_o), .DATA_BUS_OE_O(bus_oe));
  bbsp_mem_model i_mem (.pins_i(pins), .supply_i(sup), .host_d_i(bus_o), .host_oe_i(bus_oe),
    .bus_o(bus_i));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wait_for(input bit rsp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((rsp ? rspv : rdy) !== 1'b1 && n < 100);
    if ((rsp ? rspv : rdy) !== 1'b1) begin
      num_errors++;
      $display("MISMATCH wait exp 1 got 0");
      end_sim();
    end
  endtask
  task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    vld <= 1'b1;
    req <= '{w, a, d};
    wait_for(1'b0);
    @(posedge clk);
    vld <= 1'b0;
    wait_for(1'b1);
  endtask
  task automatic t_rw();
    acc(1'b1, 13'h1FFF, 8'hA5);
    acc(1'b1, 13'h0000, 8'h5A);
    acc(1'b0, 13'h1FFF, 8'h00);
    chk("rd top", 8'hA5, rdat);
    acc(1'b0, 13'h0000, 8'h00);
    chk("rd low", 8'h5A, rdat);
  endtask
  task automatic t_pwr();
    fork
      begin
        repeat (10) @(posedge clk);
        sup <= bbsp_pkg::SUPPLY_DESELECT;
      end
    join_none
    acc(1'b1, 13'h0100, 8'h3C);
    chk("abort", 8'h01, {7'h00, err});
    @(posedge clk);
    sup <= bbsp_pkg::SUPPLY_BATTERY;
    repeat (5) @(negedge clk);
    chk("rdy batt", 8'h00, {7'h00, rdy});
    @(posedge clk);
    sup <= bbsp_pkg::SUPPLY_NORMAL;
    repeat (10) @(negedge clk);
    chk("rdy rec", 8'h00, {7'h00, rdy});
    acc(1'b0, 13'h1FFF, 8'h00);
    chk("kept", 8'hA5, rdat);
    chk("err clr", 8'h00, {7'h00, err});
  endtask
  task automatic t_cut_read();
    fork
      begin
        repeat (10) @(posedge clk);
        sup <= bbsp_pkg::SUPPLY_DESELECT;
      end
    join_none
    acc(1'b0, 13'h0000, 8'h00);
    chk("rd abort", 8'h01, {7'h00, err});
    chk("rd cut", 8'hA5, rdat);
    @(posedge clk);
    sup <= bbsp_pkg::SUPPLY_NORMAL;
    acc(1'b0, 13'h0000, 8'h00);
    chk("rd after", 8'h5A, rdat);
  endtask
  initial begin
    nrst = 1'b0;
    vld = 1'b0;
    req = '0;
    sup = bbsp_pkg::SUPPLY_NORMAL;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_rw();
    t_pwr();
    t_cut_read();
    end_sim();
  end
endmodule // tb
